// >>> hw/pcs_pma_pkg.sv
// constants, carrier types and code-group tables for the 100 Mb/s coding path
// assumes a single 25 MHz system clock; the line bit clock is sampled, not used as a clock
package pcs_pma_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int HCLK_NS         = 40;
  localparam int LINE_BIT_NS     = 320;
  localparam int TX_BIT_DIV      = LINE_BIT_NS / HCLK_NS;
  localparam int SLOW_NIB_NS     = 400;
  localparam int SLOW_NIB_DIV    = SLOW_NIB_NS / HCLK_NS;
  localparam int DESCR_LOCK_BITS = 60;
  localparam int EQ_DWELL_BITS   = 1024;
  localparam int EQ_SETTINGS     = 32;

  // ----------------------------------------------------------------
  // code groups
  // ----------------------------------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1f;
  localparam logic [4:0] SYM_J    = 5'h18;
  localparam logic [4:0] SYM_K    = 5'h11;
  localparam logic [4:0] SYM_T    = 5'h0d;
  localparam logic [4:0] SYM_R    = 5'h07;
  localparam logic [4:0] SYM_H    = 5'h04;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;
  localparam logic [10:0] LFSR_SEED   = 11'h7ff;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EQ     = 8'h08;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam int CTRL_FD_BIT     = 0;
  localparam int CTRL_STREAM_BIT = 1;
  localparam int CTRL_AN_BIT     = 2;
  localparam int CTRL_EQGO_BIT   = 3;
  localparam int STS_SYMERR_BIT  = 0;
  localparam int STS_FCAR_BIT    = 1;
  localparam int EQ_BUSY_BIT     = 8;

  typedef enum logic [1:0] {TR_IDLE = 2'h0, TR_BUSY = 2'h1, TR_NONSEQ = 2'h2, TR_SEQ = 2'h3} htrans_type;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mii_tx_type;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mii_rx_type;

  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    logic [4:0] t [16];
    t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    return t[n];
  endfunction

  // nibble while tx error is asserted selects a control or invalid group
  function automatic logic [4:0] txer_5b(input logic [3:0] n);
    logic [4:0] t [16];
    t = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
          5'h08, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
    return t[n];
  endfunction

  // returns {valid, nibble}
  function automatic logic [4:0] dec_5b4b(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc_4b5b(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // eleven-stage key generator, x^11 + x^9 + 1
  function automatic logic lfsr_key(input logic [10:0] s);
    return s[10] ^ s[8];
  endfunction

  function automatic logic [10:0] lfsr_next(input logic [10:0] s);
    return {s[9:0], lfsr_key(s)};
  endfunction

endpackage

// >>> hw/pcs_pma_coding.sv
// 100 Mb/s coding path: 4b/5b, delimiters, scrambling, mlt-3, framing, equalizer choice
// assumes mii transmit inputs are synchronous to hclk; line and detector pins are asynchronous
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - in idle, a zero starts a search; first five bits must be 11000, then carrier
// - after carrier, framed second symbol must be 10001 before decoding follows
// - unconfirmed start pair raises false carrier and returns framer to idle
// - half duplex: collision on tx/rx overlap; full duplex: never collision
// - five-bit groups serialised and deserialised one bit at a time
// - nibbles map to 5-bit groups by 4b/5b table, inverse on receive
// - idle 11111, end pair 01101 then 00111, error 00100, start 11000 10001
// - undefined groups received in the data field are invalid and set the receive error status bit
// - first two preamble nibbles from mac are sent as the start pair
// - after the last nibble the end pair is sent, then idle
// - received start pair is replaced by two 0101 preamble nibbles
// - received end pair is dropped and ends frame presentation
// - with tx error, the nibble selects a control or invalid group
// - flag signal error with no receive signal, lock error without loop lock
// - receive channel is in error on lost signal or lost lock
// - with auto-negotiation on, a channel error signals remote fault to partner
// - remote fault signalled by the partner is reported
// - scramble tx and descramble rx, both bypassed in stream mode
// - tx bits go to three levels, received levels back to bits
// - equalizer tries 32 settings, keeps the best by data integrity
// - nibble enables at 25 MHz and 2.5 MHz derived from the reference
module pcs_pma_coding #(
  parameter int EQ_DWELL = pcs_pma_pkg::EQ_DWELL_BITS
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  wire pcs_pma_pkg::mii_tx_type  mii_tx,
  output logic                          tx_take,
  output pcs_pma_pkg::mii_rx_type       mii_rx,
  output logic                          rx_nib_vld,
  output logic                          crs,
  output logic                          col,
  input  wire logic                     line_clk,
  input  wire logic [1:0]               line_rx_lvl,
  output logic [1:0]                    line_tx_lvl,
  output logic                          line_tx_clk,
  input  wire logic                     sig_detect,
  input  wire logic                     pll_locked,
  input  wire logic                     lp_remote_fault,
  output logic                          remote_fault_out,
  output logic [4:0]                    eq_setting,
  output logic                          slow_nib_en
);
  import pcs_pma_pkg::*;

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_type;
  typedef enum {FR_IDLE, FR_J, FR_K, FR_DATA, FR_END} fr_state_type;
  typedef enum {EQ_IDLE, EQ_RUN} eq_state_type;

  localparam int SYM_CYC = 5 * TX_BIT_DIV;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [7:0]  dp_addr_ff;
  logic        dp_wr_ff;
  logic        ap_take;
  logic        sts_sym_err_ff;
  logic        sts_fcar_ff;
  logic        wr_ctrl;
  logic        wr_sts;
  logic        eq_go;
  logic        fd;
  logic        stream;
  logic [31:0] rd_val;
  logic        rx_inv;
  logic        fcar;
  logic        chan_err;
  logic [5:0]  s1_ff;
  logic [5:0]  s2_ff;
  eq_state_type eq_st;
  logic [4:0]  eq_best_ff;
  logic        dsc_lock_ff;
  fr_state_type fr_st;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel & hready & htrans[1];
  assign wr_ctrl   = dp_wr_ff & (dp_addr_ff == REG_CTRL);
  assign wr_sts    = dp_wr_ff & (dp_addr_ff == REG_STATUS);
  assign eq_go     = wr_ctrl & hwdata[CTRL_EQGO_BIT];
  assign fd        = ctrl_ff[CTRL_FD_BIT];
  assign stream    = ctrl_ff[CTRL_STREAM_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr_ff <= 8'h00;
      dp_wr_ff   <= 1'b0;
    end else begin
      dp_addr_ff <= haddr[7:0];
      dp_wr_ff   <= ap_take & hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= {29'h0000_0000, hwdata[2:0]};
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_sym_err_ff <= 1'b0;
      sts_fcar_ff    <= 1'b0;
    end else begin
      if (rx_inv) begin
        sts_sym_err_ff <= 1'b1;
      end else if (wr_sts & hwdata[STS_SYMERR_BIT]) begin
        sts_sym_err_ff <= 1'b0;
      end
      if (fcar) begin
        sts_fcar_ff <= 1'b1;
      end else if (wr_sts & hwdata[STS_FCAR_BIT]) begin
        sts_fcar_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      REG_CTRL:   rd_val = ctrl_ff;
      REG_STATUS: rd_val = {24'h00_0000, fr_st != FR_IDLE, dsc_lock_ff, s2_ff[5], chan_err,
                            ~s2_ff[4], ~s2_ff[3], sts_fcar_ff, sts_sym_err_ff};
      REG_EQ:     rd_val = {23'h00_0000, eq_st == EQ_RUN, 3'h0, eq_best_ff};
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take & ~hwrite) begin
      hrdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and nibble-rate enables
  // ----------------------------------------------------------------
  logic [3:0] slow_cnt_ff;
  logic       lclk_prev_ff;
  logic       rx_bit_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff        <= 6'h00;
      s2_ff        <= 6'h00;
      lclk_prev_ff <= 1'b0;
    end else begin
      s1_ff        <= {lp_remote_fault, sig_detect, pll_locked, line_rx_lvl, line_clk};
      s2_ff        <= s1_ff;
      lclk_prev_ff <= s2_ff[0];
    end
  end

  assign rx_bit_en = s2_ff[0] & ~lclk_prev_ff;
  assign chan_err  = ~s2_ff[4] | ~s2_ff[3];

  // the 25 MHz nibble rate is hclk itself; only the slow rate needs a divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_ff <= 4'h0;
      slow_nib_en <= 1'b0;
    end else begin
      slow_nib_en <= (slow_cnt_ff == 4'(SLOW_NIB_DIV - 1));
      slow_cnt_ff <= (slow_cnt_ff == 4'(SLOW_NIB_DIV - 1)) ? 4'h0 : slow_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remote_fault_out <= 1'b0;
    end else begin
      remote_fault_out <= ctrl_ff[CTRL_AN_BIT] & chan_err;
    end
  end

  // ----------------------------------------------------------------
  // transmit: encoder, serialiser, scrambler, three-level
  // ----------------------------------------------------------------
  tx_state_type tx_st;
  tx_state_type nxt_tx_st;
  logic [3:0]   tdiv_ff;
  logic [2:0]   tbit_ff;
  logic [4:0]   tsh_ff;
  logic [4:0]   nxt_sym;
  logic [10:0]  scr_ff;
  logic [1:0]   mlt_ff;
  logic         tx_bit_en;
  logic         sym_load;
  logic         scr_bit;

  assign tx_bit_en = (tdiv_ff == 4'(TX_BIT_DIV - 1));
  assign sym_load  = tx_bit_en & (tbit_ff == 3'h4);
  assign scr_bit   = stream ? tsh_ff[4] : tsh_ff[4] ^ lfsr_key(scr_ff);

  always_comb begin
    nxt_tx_st = tx_st;
    nxt_sym   = SYM_IDLE;
    tx_take   = 1'b0;
    if (sym_load) begin
      unique case (tx_st)
        TX_IDLE: if (mii_tx.en) begin
          tx_take   = 1'b1;
          nxt_sym   = SYM_J;
          nxt_tx_st = TX_K;
        end
        TX_K: begin
          tx_take   = mii_tx.en;
          nxt_sym   = SYM_K;
          nxt_tx_st = TX_DATA;
        end
        TX_DATA: if (mii_tx.en) begin
          tx_take = 1'b1;
          nxt_sym = mii_tx.er ? txer_5b(mii_tx.d) : enc_4b5b(mii_tx.d);
        end else begin
          nxt_sym   = SYM_T;
          nxt_tx_st = TX_R;
        end
        TX_R: begin
          nxt_sym   = SYM_R;
          nxt_tx_st = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdiv_ff     <= 4'h0;
      line_tx_clk <= 1'b0;
    end else begin
      tdiv_ff     <= tx_bit_en ? 4'h0 : tdiv_ff + 4'h1;
      line_tx_clk <= (tdiv_ff >= 4'(TX_BIT_DIV / 2 - 1)) & ~tx_bit_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st   <= TX_IDLE;
      tbit_ff <= 3'h0;
      tsh_ff  <= SYM_IDLE;
    end else if (tx_bit_en) begin
      tx_st   <= nxt_tx_st;
      tbit_ff <= sym_load ? 3'h0 : tbit_ff + 3'h1;
      tsh_ff  <= sym_load ? nxt_sym : {tsh_ff[3:0], 1'b0};
    end
  end

  // level index 0,1,2,3 means zero, plus, zero, minus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scr_ff      <= LFSR_SEED;
      mlt_ff      <= 2'h0;
      line_tx_lvl <= 2'h0;
    end else if (tx_bit_en) begin
      scr_ff <= lfsr_next(scr_ff);
      if (scr_bit) begin
        mlt_ff      <= mlt_ff + 2'h1;
        line_tx_lvl <= (mlt_ff == 2'h0) ? 2'h1 : (mlt_ff == 2'h2) ? 2'h3 : 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive: three-level decode, descrambler, framer, decoder
  // ----------------------------------------------------------------
  logic [1:0]   lvl_prev_ff;
  logic [10:0]  dsc_ff;
  logic [5:0]   mcnt_ff;
  logic         raw_bit;
  logic         plain;
  logic         key_ok;
  logic         rx_ok;
  logic [4:0]   sym_ff;
  logic [4:0]   symw;
  logic [4:0]   dec;
  logic [2:0]   rcnt_ff;
  logic [2:0]   nxt_rcnt;
  fr_state_type nxt_fr;
  logic         emit;
  logic         emit_er;
  logic [3:0]   emit_d;
  logic         nxt_dv;

  assign raw_bit = (s2_ff[2:1] != lvl_prev_ff);
  assign key_ok  = (lfsr_key(dsc_ff) == ~raw_bit);
  assign plain   = stream ? raw_bit : raw_bit ^ lfsr_key(dsc_ff);
  assign rx_ok   = (stream | dsc_lock_ff) & ~chan_err;
  assign symw    = {sym_ff[3:0], plain};
  assign dec     = dec_5b4b(symw);

  // while unlocked the line is assumed idle, so the key is the inverted line bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_prev_ff <= 2'h0;
      dsc_ff      <= LFSR_SEED;
      mcnt_ff     <= 6'h00;
      dsc_lock_ff <= 1'b0;
      sym_ff      <= SYM_IDLE;
    end else if (rx_bit_en) begin
      lvl_prev_ff <= s2_ff[2:1];
      sym_ff      <= symw;
      dsc_ff      <= dsc_lock_ff ? lfsr_next(dsc_ff) : {dsc_ff[9:0], ~raw_bit};
      mcnt_ff     <= key_ok ? ((mcnt_ff == 6'(DESCR_LOCK_BITS - 1)) ? mcnt_ff : mcnt_ff + 6'h01) : 6'h00;
      if (chan_err) begin
        dsc_lock_ff <= 1'b0;
      end else if (key_ok & (mcnt_ff == 6'(DESCR_LOCK_BITS - 1))) begin
        dsc_lock_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    nxt_fr   = fr_st;
    nxt_rcnt = rcnt_ff;
    nxt_dv   = mii_rx.dv;
    emit     = 1'b0;
    emit_er  = 1'b0;
    emit_d   = PREAMBLE_NIB;
    fcar     = 1'b0;
    rx_inv   = 1'b0;
    if (rx_bit_en) begin
      nxt_rcnt = rcnt_ff + 3'h1;
      unique case (fr_st)
        FR_IDLE: if (!plain) begin
          nxt_fr   = FR_J;
          nxt_rcnt = 3'h0;
        end
        FR_J: if (rcnt_ff == 3'h1) begin
          nxt_rcnt = 3'h0;
          if (symw == SYM_J) begin
            nxt_fr = FR_K;
            nxt_dv = 1'b1;
            emit   = 1'b1;
          end else begin
            nxt_fr = FR_IDLE;
            fcar   = 1'b1;
          end
        end
        FR_K: if (rcnt_ff == 3'h4) begin
          nxt_rcnt = 3'h0;
          if (symw == SYM_K) begin
            nxt_fr = FR_DATA;
            emit   = 1'b1;
          end else begin
            nxt_fr = FR_IDLE;
            nxt_dv = 1'b0;
            fcar   = 1'b1;
          end
        end
        FR_DATA: if (rcnt_ff == 3'h4) begin
          nxt_rcnt = 3'h0;
          emit_d   = dec[3:0];
          if (symw == SYM_T) begin
            nxt_fr = FR_END;
          end else if (dec[4]) begin
            emit = 1'b1;
          end else if (symw == SYM_IDLE) begin
            nxt_fr = FR_IDLE;
            nxt_dv = 1'b0;
          end else begin
            emit    = 1'b1;
            emit_er = 1'b1;
            rx_inv  = (symw != SYM_H);
          end
        end
        FR_END: if (rcnt_ff == 3'h4) begin
          nxt_fr  = FR_IDLE;
          nxt_dv  = 1'b0;
          emit    = (symw != SYM_R);
          emit_er = (symw != SYM_R);
        end
      endcase
    end
    if (!rx_ok) begin
      nxt_fr = FR_IDLE;
      nxt_dv = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_st      <= FR_IDLE;
      rcnt_ff    <= 3'h0;
      mii_rx     <= '0;
      rx_nib_vld <= 1'b0;
    end else begin
      fr_st      <= nxt_fr;
      rcnt_ff    <= nxt_rcnt;
      mii_rx.dv  <= nxt_dv;
      rx_nib_vld <= emit;
      if (emit) begin
        mii_rx.d  <= emit_d;
        mii_rx.er <= emit_er;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= (fr_st != FR_IDLE) | (~fd & (tx_st != TX_IDLE));
      col <= ~fd & (fr_st != FR_IDLE) & (tx_st != TX_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // adaptive equalizer search
  // ----------------------------------------------------------------
  logic [4:0]  eq_try_ff;
  logic [15:0] eq_win_ff;
  logic [15:0] eq_err_ff;
  logic [15:0] eq_min_ff;
  logic [15:0] eq_tot;
  logic        eq_bad;

  // integrity measure: unlocked bits, or zeros seen while the line should idle
  assign eq_bad = rx_bit_en & (~dsc_lock_ff | ((fr_st == FR_IDLE) & ~plain));
  assign eq_tot = eq_err_ff + {15'h0000, eq_bad};
  assign eq_setting = (eq_st == EQ_RUN) ? eq_try_ff : eq_best_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_st      <= EQ_IDLE;
      eq_try_ff  <= 5'h00;
      eq_best_ff <= 5'h00;
      eq_win_ff  <= 16'h0000;
      eq_err_ff  <= 16'h0000;
      eq_min_ff  <= 16'hffff;
    end else if (eq_st == EQ_IDLE) begin
      if (eq_go) begin
        eq_st     <= EQ_RUN;
        eq_try_ff <= 5'h00;
        eq_win_ff <= 16'h0000;
        eq_err_ff <= 16'h0000;
        eq_min_ff <= 16'hffff;
      end
    end else if (rx_bit_en) begin
      eq_win_ff <= eq_win_ff + 16'h0001;
      eq_err_ff <= eq_tot;
      if (eq_win_ff == 16'(EQ_DWELL - 1)) begin
        eq_win_ff <= 16'h0000;
        eq_err_ff <= 16'h0000;
        eq_try_ff <= eq_try_ff + 5'h01;
        if (eq_tot < eq_min_ff) begin
          eq_min_ff  <= eq_tot;
          eq_best_ff <= eq_try_ff;
        end
        if (eq_try_ff == 5'(EQ_SETTINGS - 1)) begin
          eq_st <= EQ_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence end_t_seq;
    sym_load && tx_st == TX_DATA && !mii_tx.en ##1 tsh_ff == SYM_T;
  endsequence

  sequence end_r_seq;
    ##[1:SYM_CYC] sym_load ##1 tsh_ff == SYM_R && tx_st == TX_IDLE;
  endsequence

  a_col_full_dup: assert property (@(posedge hclk) disable iff (!hresetn)
    fd && $past(fd) |-> !col) else $error("collision in full duplex");

  a_col_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
    !fd && fr_st != FR_IDLE && tx_st != TX_IDLE |=> col) else $error("overlap without collision");

  a_tx_start_j: assert property (@(posedge hclk) disable iff (!hresetn)
    sym_load && tx_st == TX_IDLE && mii_tx.en |=> tsh_ff == SYM_J ##[1:SYM_CYC] tsh_ff == SYM_K)
    else $error("start pair not sent");

  a_tx_end_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    end_t_seq |-> end_r_seq) else $error("end pair not sent");

  a_txer_group: assert property (@(posedge hclk) disable iff (!hresetn)
    sym_load && tx_st == TX_DATA && mii_tx.en && mii_tx.er |=> tsh_ff == txer_5b($past(mii_tx.d)))
    else $error("tx error nibble mapped wrong");

  a_sym_err_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_inv |=> sts_sym_err_ff [*2]) else $error("invalid group not recorded");

  a_false_car_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    fcar |=> fr_st == FR_IDLE && !mii_rx.dv && sts_fcar_ff) else $error("false carrier not handled");

  a_k_preamble: assert property (@(posedge hclk) disable iff (!hresetn)
    fr_st == FR_K && nxt_fr == FR_DATA |=> rx_nib_vld && mii_rx.d == PREAMBLE_NIB && mii_rx.dv)
    else $error("preamble nibble not substituted");

  a_mlt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_bit_en && !scr_bit |=> $stable(line_tx_lvl)) else $error("level moved on zero bit");

  a_remote_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff[CTRL_AN_BIT] && chan_err ##1 ctrl_ff[CTRL_AN_BIT] && chan_err |-> remote_fault_out)
    else $error("remote fault not signalled");

endmodule // pcs_pma_coding

// >>> verif/mii_mac_model.sv
// mac stand-in on the transmit nibble side: one short frame per go pulse
// assumes tx_take marks the cycle in which the coding path consumes a nibble
`timescale 1ns/1ps
module mii_mac_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               go,
  input  wire logic               tx_take,
  output pcs_pma_pkg::mii_tx_type mii_tx
);
  import pcs_pma_pkg::*;
  // {er, nibble}: two preamble nibbles, one data nibble, one forced error group
  localparam logic [4:0] FRM [4] = '{5'h05, 5'h05, 5'h0a, 5'h14};
  logic [2:0] idx_ff;
  logic [3:0] junk_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_ff <= 3'h4;
    end else if (go) begin
      idx_ff <= 3'h0;
    end else if (tx_take && idx_ff < 3'h4) begin
      idx_ff <= idx_ff + 3'h1;
    end
  end
  // released data lines keep changing so a stale nibble is never mistaken for a held one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      junk_ff <= 4'h0;
    end else begin
      junk_ff <= ~junk_ff;
    end
  end
  assign mii_tx = (idx_ff < 3'h4) ? {1'b1, FRM[idx_ff[1:0]]} : {2'b00, junk_ff};
endmodule // mii_mac_model

// >>> verif/pcs_pma_coding_tb.sv
// self-checking bench for the 100 Mb/s coding path
// assumes the bench plays the cable partner and the mac model the nibble source
`timescale 1ns/1ps
module pcs_pma_coding_tb;
  import pcs_pma_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, b, cseen;
  logic line_clk = 0, sig_detect = 1, pll_locked = 1, lp_remote_fault = 0;
  logic hreadyout, tx_take, rx_nib_vld, col, line_tx_clk, remote_fault_out, crs, sne, rseen;
  logic [4:0]  eqs;
  int sn = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, st;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans = 0, line_rx_lvl = 0, line_tx_lvl, tlv = 0, ph = 0;
  logic [29:0] txs = 0;
  logic [4:0]  rxq[$];
  logic        rq[$];
  mii_tx_type  mii_tx;
  mii_rx_type  mii_rx;
  int err_count = 0, n_tests = 0;

  pcs_pma_coding #(.EQ_DWELL(8)) i_pcs_pma_coding (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .mii_tx, .tx_take, .mii_rx,
    .rx_nib_vld, .crs, .col, .line_clk, .line_rx_lvl, .line_tx_lvl, .line_tx_clk, .sig_detect,
    .pll_locked, .lp_remote_fault, .remote_fault_out, .eq_setting(eqs), .slow_nib_en(sne));
  mii_mac_model i_mii_mac_model (.hclk, .hresetn, .go, .tx_take, .mii_tx);

  always #20 hclk = ~hclk;
  initial begin #7; forever #160 line_clk = ~line_clk; end
  // partner line: three-level code, idle ones when nothing is queued
  always @(negedge line_clk) begin
    b = rq.size() ? rq.pop_front() : 1'b1;
    if (b) ph = ph + 2'h1;
    line_rx_lvl = ph[0] ? {ph[1], 1'b1} : 2'b00;
  end
  always @(posedge line_tx_clk) begin
    txs <= {txs[28:0], line_tx_lvl != tlv};
    tlv <= line_tx_lvl;
  end
  always @(posedge hclk) begin
    if (rx_nib_vld) rxq.push_back({mii_rx.er, mii_rx.d});
    if (col) cseen = 1;
    if (crs) rseen = 1;
    if (sne) sn++;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1; haddr <= {24'h00_0000, a}; htrans <= TR_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= TR_IDLE; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    st = hrdata;
  endtask
  task sym(input logic [4:0] s);
    for (int i = 4; i >= 0; i--) rq.push_back(s[i]);
  endtask
  task settle;
    for (int n = 0; n < 400 && rq.size() != 0; n++) @(posedge hclk);
    repeat (15 * TX_BIT_DIV) @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    ahb(0, REG_CTRL, 0); chk("ctrl reset", CTRL_RST, st);
    ahb(1, 8'h40, 32'hffff_ffff); ahb(0, 8'h40, 0); chk("unmapped", 0, st);
    ahb(0, REG_EQ, 0); chk("eq reset", 0, st);
    $display("register test done");
  endtask
  task t_fault;
    ahb(1, REG_CTRL, 32'h0000_0004);
    sig_detect <= 0; lp_remote_fault <= 1;
    repeat (6) @(posedge hclk);
    chk("fault out", 1, remote_fault_out);
    ahb(0, REG_STATUS, 0); chk("signal error", 32'h38, st & 32'h3c);
    sig_detect <= 1; pll_locked <= 0; lp_remote_fault <= 0;
    repeat (6) @(posedge hclk);
    chk("fault out", 1, remote_fault_out);
    ahb(0, REG_STATUS, 0); chk("lock error", 32'h14, st & 32'h3c);
    pll_locked <= 1;
    $display("fault test done");
  endtask
  task t_frame(input logic fd);
    logic [29:0] ex;
    ex = {SYM_J, SYM_K, 5'h16, SYM_H, SYM_T, SYM_R};
    ahb(1, REG_CTRL, {30'h0, 1'b1, fd});
    repeat (2 * DESCR_LOCK_BITS * TX_BIT_DIV) @(posedge hclk);
    rxq.delete(); cseen = 0; rseen = 0; go <= 1;
    sym(SYM_J); sym(SYM_K); sym(5'h16); sym(5'h00); sym(SYM_T); sym(SYM_R);
    @(posedge hclk); go <= 0;
    for (int n = 0; n < 400 && txs !== ex; n++) @(posedge hclk);
    chk("tx groups", ex, txs);
    settle;
    chk("rx count", 4, rxq.size());
    chk("rx j", 5'h05, rxq[0]);
    chk("rx k", 5'h05, rxq[1]);
    chk("rx data", 5'h0a, rxq[2]);
    chk("rx invalid", 1, rxq[3][4]);
    chk("rx dv", 0, mii_rx.dv);
    chk("collision", !fd, cseen);
    chk("carrier", 1, rseen);
    ahb(0, REG_STATUS, 0); chk("symbol error", 1, st[STS_SYMERR_BIT]);
    ahb(1, REG_STATUS, 32'h0000_0003); ahb(0, REG_STATUS, 0); chk("status clear", 0, st[1:0]);
    $display("frame test done, full duplex %0d", fd);
  endtask
  task t_eq;
    int n;
    ahb(1, REG_CTRL, 32'h0000_000a); ahb(0, REG_EQ, 0);
    chk("eq busy", 1, st[EQ_BUSY_BIT]);
    for (int k = 0; k < 4000 && st[EQ_BUSY_BIT]; k++) ahb(0, REG_EQ, 0);
    chk("eq done", 0, st[EQ_BUSY_BIT]);
    chk("eq best", 0, st[4:0]);
    chk("eq setting", 0, eqs);
    n = sn;
    repeat (100) @(posedge hclk);
    chk("slow enable", 10, sn - n);
    $display("equalizer test done");
  endtask
  task t_fcar;
    sym(SYM_J); sym(SYM_IDLE);
    settle;
    ahb(0, REG_STATUS, 0); chk("false carrier", 1, st[STS_FCAR_BIT]);
    chk("fc dv", 0, mii_rx.dv);
    $display("false carrier test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    t_regs; t_fault; t_frame(0); t_frame(1); t_eq; t_fcar;
    conclude;
  end
  initial begin
    #1_000_000;
    err_count++;
    conclude;
  end
endmodule // pcs_pma_coding_tb
